// [common/timer_pkg.sv]
// Constants, field layouts and carrier types for the timer global control block.
// What this block does
// - Up counting sets the overflow flag when the counter wraps to zero after modulo.
// - Center mode sets the overflow flag on the step down after reaching modulo.
// - Overflow flag clears only by status read while set, then writing zero.
// - An overflow between that read and write disarms the clear, so the flag stays set.
// - Writing one to the flag does nothing; reset clears the whole status register.
// - Interrupt request is flag and enable bit 6 together; otherwise software polls.
// - Bit 5 clear counts up; set counts up and down with center PWM on channels.
// - With bit 5 clear each channel follows its own mode select bits.
// - Clock field bits 4:3 picks none, bus rate, fixed system or external pin.
// - External and fixed clocks are synchronised to the bus clock before the prescaler.
// - Prescale field bits 2:0 divides the selected clock by two to that power.
// - Counter bytes are read-only; reading one latches both until the other is read.
// - Reset, counter byte writes and status writes restart the read latch.
// - Reset clears the counter to zero.
// - Any write to a counter byte resets the counter; reads never disturb it.
// - Modulo of all zeros or all ones gives a free-running full-range counter.
// - After modulo the counter restarts from zero, or turns down in center mode.
// - In background debug mode the counter and read latch freeze, even on reads.
package timer_pkg;
  localparam int ADDR_W = 2;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_CNT_HI = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_CNT_LO = 2'h2;
  localparam logic [ADDR_W-1:0] ADDR_MOD_HI = 2'h3;
  localparam int BIT_FLAG = 7;
  localparam int BIT_IRQ_EN = 6;
  localparam int BIT_CENTER = 5;
  localparam int CLK_HI = 4;
  localparam int CLK_LO = 3;
  localparam int PS_HI = 2;
  localparam int PS_LO = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE = 16'h0001;
  localparam logic [15:0] COUNT_FULL = 16'hFFFF;
  localparam logic [7:0] MOD_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [6:0] PRESC_ZERO = 7'h00;
  localparam logic [6:0] PRESC_ONE = 7'h01;
  typedef enum logic [1:0] {SRC_NONE, SRC_BUS, SRC_FIXED, SRC_EXT} clk_src_t;
  typedef struct packed {
    logic center_align_select;
    logic count_down;
    logic [15:0] count;
  } counter_view_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : timer_pkg

// [verilog/timer_counter_global_control.sv]
// Timer global control: status register, clock select, prescaler, counter and read latch.
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module timer_counter_global_control
  import timer_pkg::*;
#(
  parameter int COUNT_W = 16,
  parameter int PS_STAGES = 7
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire reg_req_t req_in,
  output logic [7:0] rdata_out,
  input wire logic fixed_system_clock_in,
  input wire logic external_timer_clock_pin_in,
  input wire logic debug_active_in,
  input wire logic [7:0] modulo_lo_in,
  output logic overflow_irq_out,
  output logic overflow_event_out,
  output counter_view_t counter_view_out
);
  // The byte layout and prescaler tap counter are fixed by the register map.
  if (COUNT_W != 16 || PS_STAGES != 7) begin : g_bad_params
    $error("timer_counter_global_control supports only a 16-bit counter and 7 stages");
  end

  logic overflow_flag;
  logic overflow_irq_enable;
  logic center_align_select;
  logic [1:0] clock_source_field;
  logic [2:0] prescale_field;
  logic flag_armed;
  logic [15:0] count;
  logic count_down;
  logic [7:0] modulo_hi;
  logic [15:0] latch;
  logic latch_full;
  logic fix_s1, fix_s2, fix_s3;
  logic ext_s1, ext_s2, ext_s3;
  logic [6:0] presc;
  logic src_tick;
  logic step;
  logic at_top;
  logic overflow;
  logic next_dir_down;
  logic [15:0] next_count;
  logic [15:0] modulo_value;
  logic wr_status;
  logic rd_status;
  logic wr_count;
  logic rd_count;
  logic [ADDR_W-1:0] first_addr;
  logic [7:0] status_byte;

  // Access decode from the plain register port.
  assign wr_status = req_in.wr && req_in.addr == ADDR_STATUS;
  assign rd_status = req_in.rd && req_in.addr == ADDR_STATUS;
  assign wr_count = req_in.wr && (req_in.addr == ADDR_CNT_HI || req_in.addr == ADDR_CNT_LO);
  assign rd_count = req_in.rd && (req_in.addr == ADDR_CNT_HI || req_in.addr == ADDR_CNT_LO);
  assign modulo_value = {modulo_hi, modulo_lo_in};
  assign status_byte = {overflow_flag, overflow_irq_enable, center_align_select,
                        clock_source_field, prescale_field};

  // Two-stage synchronisers; the third stage gives a clean edge for each source.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fix_s1 <= 1'b0;
      fix_s2 <= 1'b0;
      fix_s3 <= 1'b0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      fix_s1 <= fixed_system_clock_in;
      fix_s2 <= fix_s1;
      fix_s3 <= fix_s2;
      ext_s1 <= external_timer_clock_pin_in;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end

  // Source select; synchronised sources tick once per rising edge.
  always_comb begin
    unique case (clk_src_t'(clock_source_field))
      SRC_NONE: src_tick = 1'b0;
      SRC_BUS: src_tick = 1'b1;
      SRC_FIXED: src_tick = fix_s2 && !fix_s3;
      SRC_EXT: src_tick = ext_s2 && !ext_s3;
    endcase
  end

  // Prescaler: a step when the low prescale_field bits of the tap counter are all zero.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      presc <= PRESC_ZERO;
    end else if (wr_count || clock_source_field == 2'(SRC_NONE)) begin
      presc <= PRESC_ZERO;
    end else if (src_tick && !debug_active_in) begin
      presc <= presc + PRESC_ONE;
    end
  end
  assign step = src_tick && !debug_active_in &&
                ((presc & ((PRESC_ONE << prescale_field) - PRESC_ONE)) == PRESC_ZERO);

  // Terminal count: zero and all-ones modulo both run over the full range.
  assign at_top = (modulo_value == COUNT_ZERO || modulo_value == COUNT_FULL) ?
                  (count == COUNT_FULL) : (count == modulo_value);

  // Next counter value and direction.
  always_comb begin
    next_count = count + COUNT_ONE;
    next_dir_down = count_down;
    overflow = 1'b0;
    if (!center_align_select) begin
      next_dir_down = 1'b0;
      if (at_top) begin
        next_count = COUNT_ZERO;
        overflow = 1'b1;
      end
    end else if (count_down || at_top) begin
      next_count = count - COUNT_ONE;
      next_dir_down = 1'b1;
      overflow = at_top;
      if (count == COUNT_ONE) begin
        next_dir_down = 1'b0;
      end
    end
  end

  // Counter and direction.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= COUNT_ZERO;
      count_down <= 1'b0;
    end else if (wr_count) begin
      count <= COUNT_ZERO;
      count_down <= 1'b0;
    end else if (step) begin
      count <= next_count;
      count_down <= next_dir_down;
    end
  end
  assign overflow_event_out = step && overflow;

  // Control fields; the flag bit is not writable as one.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      overflow_irq_enable <= STATUS_RESET[BIT_IRQ_EN];
      center_align_select <= STATUS_RESET[BIT_CENTER];
      clock_source_field <= STATUS_RESET[CLK_HI:CLK_LO];
      prescale_field <= STATUS_RESET[PS_HI:PS_LO];
    end else if (wr_status) begin
      overflow_irq_enable <= req_in.wdata[BIT_IRQ_EN];
      center_align_select <= req_in.wdata[BIT_CENTER];
      clock_source_field <= req_in.wdata[CLK_HI:CLK_LO];
      prescale_field <= req_in.wdata[PS_HI:PS_LO];
    end
  end

  // Overflow flag and its read-then-write-zero clear; a new overflow wins and disarms.
  // The two-access clear means an overflow landing between the accesses is never lost.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      overflow_flag <= STATUS_RESET[BIT_FLAG];
      flag_armed <= 1'b0;
    end else if (overflow_event_out) begin
      overflow_flag <= 1'b1;
      flag_armed <= 1'b0;
    end else if (rd_status && overflow_flag) begin
      flag_armed <= 1'b1;
    end else if (wr_status) begin
      if (flag_armed && !req_in.wdata[BIT_FLAG]) begin
        overflow_flag <= 1'b0;
      end
      flag_armed <= 1'b0;
    end
  end
  assign overflow_irq_out = overflow_flag && overflow_irq_enable;

  // Modulo high byte, held here; the low byte comes from the modulo logic.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      modulo_hi <= MOD_ZERO;
    end else if (req_in.wr && req_in.addr == ADDR_MOD_HI) begin
      modulo_hi <= req_in.wdata;
    end
  end

  // Coherent read latch: first byte read fills it, the other byte read releases it.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch <= COUNT_ZERO;
      latch_full <= 1'b0;
    end else if (wr_count || wr_status) begin
      latch_full <= 1'b0;
    end else if (rd_count && !debug_active_in) begin
      // A repeat read of the opening byte returns the held half and keeps it full.
      if (!latch_full) begin
        latch <= count;
        latch_full <= 1'b1;
      end else if (req_in.addr != first_addr) begin
        latch_full <= 1'b0;
      end
    end
  end

  // Remember which byte opened the latch.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      first_addr <= ADDR_STATUS;
    end else if (rd_count && !latch_full && !debug_active_in) begin
      first_addr <= req_in.addr;
    end
  end

  // Read data one cycle after the strobe.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= BYTE_ZERO;
    end else if (req_in.rd) begin
      unique case (req_in.addr)
        ADDR_STATUS: rdata_out <= status_byte;
        ADDR_CNT_HI: rdata_out <= latch_full ? latch[15:8] : count[15:8];
        ADDR_CNT_LO: rdata_out <= latch_full ? latch[7:0] : count[7:0];
        ADDR_MOD_HI: rdata_out <= modulo_hi;
      endcase
    end else begin
      rdata_out <= BYTE_ZERO;
    end
  end

  // View of the counter shared with the channel logic.
  assign counter_view_out = '{center_align_select: center_align_select,
                              count_down: count_down, count: count};

  // Assertions.
  property p_flag_set;
    @(posedge clk_in) disable iff (!rst_n_in) overflow_event_out |=> overflow_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set on overflow");
  property p_up_wrap;
    @(posedge clk_in) disable iff (!rst_n_in)
      (step && !center_align_select && at_top && !wr_count) |=> count == COUNT_ZERO;
  endproperty
  a_up_wrap: assert property (p_up_wrap) else $error("counter did not wrap");
  property p_irq;
    @(posedge clk_in) disable iff (!rst_n_in)
      (overflow_event_out && overflow_irq_enable && !wr_status) |=> overflow_irq_out;
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_no_clock;
    @(posedge clk_in) disable iff (!rst_n_in)
      (clock_source_field == 2'b00 && !wr_count) |=> $stable(count);
  endproperty
  a_no_clock: assert property (p_no_clock) else $error("counter moved with no clock");
  property p_cnt_write;
    @(posedge clk_in) disable iff (!rst_n_in) wr_count |=> count == COUNT_ZERO && !latch_full;
  endproperty
  a_cnt_write: assert property (p_cnt_write) else $error("counter write ignored");
  property p_debug_freeze;
    @(posedge clk_in) disable iff (!rst_n_in)
      (debug_active_in && !wr_count && !wr_status) |=> $stable(count) && $stable(latch_full);
  endproperty
  a_debug_freeze: assert property (p_debug_freeze) else $error("debug freeze broken");
  property p_clear_needs_read;
    @(posedge clk_in) disable iff (!rst_n_in) (overflow_flag && !flag_armed) |=> overflow_flag;
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read) else $error("flag cleared early");
  property p_status_write;
    @(posedge clk_in) disable iff (!rst_n_in) wr_status |=> !latch_full && !flag_armed;
  endproperty
  a_status_write: assert property (p_status_write) else $error("status write no restart");

  // Source ticks since the last step; valid only once a step has set the phase.
  logic [6:0] tick_gap;
  logic gap_valid;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_gap <= PRESC_ZERO;
      gap_valid <= 1'b0;
    end else if (wr_count || wr_status) begin
      tick_gap <= PRESC_ZERO;
      gap_valid <= 1'b0;
    end else if (step) begin
      tick_gap <= PRESC_ZERO;
      gap_valid <= 1'b1;
    end else if (src_tick && !debug_active_in) begin
      tick_gap <= tick_gap + PRESC_ONE;
    end
  end
  property p_prescale;
    @(posedge clk_in) disable iff (!rst_n_in)
      (step && gap_valid) |-> tick_gap == ((PRESC_ONE << prescale_field) - PRESC_ONE);
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler divide wrong");

  // Flag sequence checks.
  property p_flag_clear;
    @(posedge clk_in) disable iff (!rst_n_in)
      (wr_status && flag_armed && !req_in.wdata[BIT_FLAG] && !overflow_event_out) |=>
        !overflow_flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("armed clear ignored");
  property p_rearm;
    @(posedge clk_in) disable iff (!rst_n_in) overflow_event_out |=> !flag_armed;
  endproperty
  a_rearm: assert property (p_rearm) else $error("overflow did not restart clear");
  property p_flag_only_event;
    @(posedge clk_in) disable iff (!rst_n_in)
      (!overflow_flag && !overflow_event_out) |=> !overflow_flag;
  endproperty
  a_flag_only_event: assert property (p_flag_only_event) else $error("flag set by write");

  // Counting direction and clock source checks.
  property p_center_turn;
    @(posedge clk_in) disable iff (!rst_n_in)
      (step && center_align_select && at_top && !wr_count) |=> overflow_flag &&
        count == $past(count) - COUNT_ONE;
  endproperty
  a_center_turn: assert property (p_center_turn) else $error("center turn wrong");
  property p_up_only;
    @(posedge clk_in) disable iff (!rst_n_in)
      (step && !center_align_select && !wr_count) |=> !count_down;
  endproperty
  a_up_only: assert property (p_up_only) else $error("counted down in up mode");
  property p_bus_tick;
    @(posedge clk_in) disable iff (!rst_n_in)
      (clock_source_field == 2'(SRC_BUS) && prescale_field == '0 && !debug_active_in) |-> step;
  endproperty
  a_bus_tick: assert property (p_bus_tick) else $error("bus clock missed a step");
  property p_sync_fixed;
    @(posedge clk_in) disable iff (!rst_n_in)
      (clock_source_field == 2'(SRC_FIXED) && !fix_s2) |-> !step;
  endproperty
  a_sync_fixed: assert property (p_sync_fixed) else $error("unsynchronised step");

  // Read latch checks.
  property p_latch_hold;
    @(posedge clk_in) disable iff (!rst_n_in)
      (latch_full && !wr_count && !wr_status) |=> $stable(latch);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched value moved");
  property p_read_quiet;
    @(posedge clk_in) disable iff (!rst_n_in)
      (req_in.rd && !step) |=> $stable(count);
  endproperty
  a_read_quiet: assert property (p_read_quiet) else $error("read disturbed counter");
  c_overflow: cover property (@(posedge clk_in) disable iff (!rst_n_in) overflow_event_out);
  c_clear: cover property (@(posedge clk_in) disable iff (!rst_n_in) $fell(overflow_flag));
  c_center: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(count_down));
  c_rearm: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    flag_armed && overflow_event_out);
  c_slow_step: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    step && gap_valid && &prescale_field);
endmodule : timer_counter_global_control

// [verif/tb_timer_counter_global_control.sv]
// Self-checking bench for the timer global control block.
`timescale 1ns/1ps
module tb_timer_counter_global_control;
  import timer_pkg::*;
  logic clk_in;
  logic rst_n_in;
  reg_req_t req;
  logic [7:0] rdata;
  logic fix_clk;
  logic ext_clk;
  logic dbg;
  logic [7:0] mod_lo;
  logic irq;
  logic ovf_ev;
  counter_view_t view;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [7:0] d;

  timer_counter_global_control DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req),
    .rdata_out(rdata), .fixed_system_clock_in(fix_clk), .external_timer_clock_pin_in(ext_clk),
    .debug_active_in(dbg), .modulo_lo_in(mod_lo), .overflow_irq_out(irq),
    .overflow_event_out(ovf_ev), .counter_view_out(view));

  // Clock of 4 ns period.
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // Cuts a hang short once the cycle ceiling is reached.
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_in);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    req <= '{addr: a, wdata: v, wr: 1'b0, rd: 1'b0};
  endtask : wr

  // Read data stand only in the cycle after the strobe, so it is taken just past that edge.
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_in);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    #1 v = rdata;
  endtask : rd

  // Slow pulses, eight cycles each, well under a quarter of the bus rate.
  task automatic pulses(input bit ext, input int n);
    repeat (n) begin
      @(posedge clk_in);
      if (ext) ext_clk <= 1'b1; else fix_clk <= 1'b1;
      repeat (4) @(posedge clk_in);
      if (ext) ext_clk <= 1'b0; else fix_clk <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
    repeat (4) @(posedge clk_in);
  endtask : pulses

  // Waits, bounded, for the edge that takes the overflow step, then lets it land.
  task automatic wait_ev;
    int k;
    k = 0;
    @(negedge clk_in);
    while (ovf_ev !== 1'b1 && k < 100) begin
      @(negedge clk_in);
      k++;
    end
    chk("overflow_event", 16'h0001, {15'h0000, ovf_ev});
    @(posedge clk_in);
    #1;
  endtask : wait_ev

  // Main sequence of tests.
  initial begin
    req = '{addr: 2'h0, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    fix_clk = 1'b0;
    ext_clk = 1'b0;
    dbg = 1'b0;
    mod_lo = 8'h00;
    rst_n_in = 1'b0;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(ADDR_STATUS, d);
    chk("status", 16'h0000, d);
    chk("count", 16'h0000, view.count);
    chk("irq", 16'h0000, irq);
    $display("test reset done");
    // Every divisor, largest first; one pulse past the divisor gives exactly two steps.
    // No channel shares the clock pin here, so no edge/level bits need clearing.
    for (int ps = 7; ps >= 0; ps--) begin
      wr(ADDR_CNT_HI, 8'h00);
      wr(ADDR_STATUS, 8'h18 | 8'(ps));
      pulses(1, (1 << ps) + 1);
      rd(ADDR_CNT_LO, d);
      chk("count_lo", 16'h0002, d);
      rd(ADDR_CNT_HI, d);
      chk("count_hi", 16'h0000, d);
    end
    $display("test prescaler done");
    wr(ADDR_CNT_LO, 8'h00);
    wr(ADDR_STATUS, 8'h10);
    pulses(0, 300);
    rd(ADDR_CNT_HI, d);
    chk("count_hi", 16'h0001, d);
    pulses(0, 10);
    rd(ADDR_CNT_LO, d);
    chk("count_lo", 16'h002c, d);
    rd(ADDR_CNT_LO, d);
    chk("count_lo", 16'h0036, d);
    rd(ADDR_CNT_HI, d);
    chk("count_hi", 16'h0001, d);
    @(posedge clk_in);
    dbg <= 1'b1;
    pulses(0, 5);
    dbg <= 1'b0;
    rd(ADDR_CNT_LO, d);
    chk("count_lo", 16'h0036, d);
    rd(ADDR_CNT_HI, d);
    wr(ADDR_CNT_LO, 8'h5a);
    rd(ADDR_CNT_LO, d);
    chk("count_lo", 16'h0000, d);
    rd(ADDR_CNT_HI, d);
    rd(ADDR_CNT_HI, d);
    wr(ADDR_STATUS, 8'h10);
    pulses(0, 3);
    rd(ADDR_CNT_LO, d);
    chk("count_lo", 16'h0003, d);
    rd(ADDR_CNT_HI, d);
    wr(ADDR_STATUS, 8'h00);
    pulses(0, 5);
    pulses(1, 5);
    rd(ADDR_CNT_LO, d);
    chk("count_lo", 16'h0003, d);
    $display("test latch done");
    wr(ADDR_MOD_HI, 8'h3c);
    rd(ADDR_MOD_HI, d);
    chk("modulo_hi", 16'h003c, d);
    wr(ADDR_MOD_HI, 8'h00);
    wr(ADDR_CNT_HI, 8'h00);
    @(posedge clk_in);
    mod_lo <= 8'h09;
    wr(ADDR_STATUS, 8'h48);
    wait_ev();
    chk("count", 16'h0000, view.count);
    chk("irq", 16'h0001, irq);
    rd(ADDR_STATUS, d);
    wr(ADDR_STATUS, 8'hc8);
    rd(ADDR_STATUS, d);
    chk("status", 16'h00c8, d);
    wait_ev();
    rd(ADDR_STATUS, d);
    wr(ADDR_STATUS, 8'h48);
    rd(ADDR_STATUS, d);
    chk("status", 16'h0048, d);
    chk("irq", 16'h0000, irq);
    wait_ev();
    rd(ADDR_STATUS, d);
    wait_ev();
    wr(ADDR_STATUS, 8'h48);
    rd(ADDR_STATUS, d);
    chk("status", 16'h00c8, d);
    wait_ev();
    wr(ADDR_STATUS, 8'h08);
    rd(ADDR_STATUS, d);
    chk("status", 16'h0088, d);
    chk("irq", 16'h0000, irq);
    $display("test overflow done");
    rd(ADDR_STATUS, d);
    wr(ADDR_STATUS, 8'h28);
    wait_ev();
    chk("count", 16'h0008, view.count);
    chk("center", 16'h0001, view.center_align_select);
    chk("count_down", 16'h0001, view.count_down);
    rd(ADDR_STATUS, d);
    chk("status", 16'h00a8, d);
    $display("test center done");
    end_sim();
  end
endmodule : tb_timer_counter_global_control
